// ### pkg/nv_pkg.sv
// Constants shared by the nonvolatile access controller.
// Assumes a 200 MHz system clock and an AXI4-Lite master.
package nv_pkg;
    localparam int unsigned CLK_FREQ_MHZ  = 200;
    localparam int unsigned WRITE_TIME_US = 4000;
    localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned PWRT_TIME_US  = 64000;
    localparam int unsigned PWRT_CYCLES   = PWRT_TIME_US * CLK_FREQ_MHZ;

    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK  = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam logic [7:0] OFS_ADDRESS = 8'h0c;
    localparam logic [7:0] OFS_FLAGS   = 8'h10;

    localparam int unsigned CTL_SPACE  = 7;
    localparam int unsigned CTL_CONFIG = 6;
    localparam int unsigned CTL_ERASE  = 4;
    localparam int unsigned CTL_ABORT  = 3;
    localparam int unsigned CTL_PERMIT = 2;
    localparam int unsigned CTL_WGO    = 1;
    localparam int unsigned CTL_RGO    = 0;

    localparam int unsigned FLG_DONE   = 0;
    localparam int unsigned FLG_PWRT   = 1;
    localparam int unsigned FLG_BUSY   = 2;

    localparam logic [7:0] KEY_FIRST   = 8'h55;
    localparam logic [7:0] KEY_SECOND  = 8'haa;
    localparam logic [7:0] RST_BYTE    = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_CONTROL, SEL_UNLOCK, SEL_DATA, SEL_ADDRESS, SEL_FLAGS, SEL_NONE
    } reg_sel_t;
    typedef enum logic [1:0] { UNL_IDLE, UNL_KEY1, UNL_ARMED } unlock_t;
    typedef enum logic { WR_IDLE, WR_BUSY } wr_state_t;
endpackage

// ### design/nv_access_ctrl.sv
// Nonvolatile byte array access controller with AXI4-Lite register slave.
// Assumes single clock, synchronous reset as power-on, warm reset from logic.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module nv_access_ctrl #(
    parameter int unsigned WRITE_CYCLES = nv_pkg::WRITE_CYCLES,
    parameter int unsigned PWRT_CYCLES  = nv_pkg::PWRT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        warm_rst_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             write_busy_o
);

    function automatic nv_pkg::reg_sel_t reg_sel(input logic [7:0] a);
        if (a == nv_pkg::OFS_CONTROL) begin
            return nv_pkg::SEL_CONTROL;
        end else if (a == nv_pkg::OFS_UNLOCK) begin
            return nv_pkg::SEL_UNLOCK;
        end else if (a == nv_pkg::OFS_DATA) begin
            return nv_pkg::SEL_DATA;
        end else if (a == nv_pkg::OFS_ADDRESS) begin
            return nv_pkg::SEL_ADDRESS;
        end else if (a == nv_pkg::OFS_FLAGS) begin
            return nv_pkg::SEL_FLAGS;
        end else begin
            return nv_pkg::SEL_NONE;
        end
    endfunction

    // Bus slave state
    logic                aw_held_q;
    logic [7:0]          awaddr_q;
    logic                w_held_q;
    logic [7:0]          wdata_q;
    logic                wstrb0_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;

    // Access control state
    logic                space_q;
    logic                config_q;
    logic                erase_q;
    logic                abort_q;
    logic                permit_q;
    logic                wgo_q;
    logic                rgo_q;
    logic [7:0]          addr_q;
    logic [7:0]          data_q;
    logic                done_q;
    logic [7:0]          mem_q [256];
    nv_pkg::unlock_t     unl_q;
    nv_pkg::wr_state_t   st_q;
    logic [31:0]         cnt_q;
    logic [31:0]         pwrt_cnt_q;
    logic                pwrt_done_q;

    // Decoding
    nv_pkg::reg_sel_t    wr_sel;
    nv_pkg::reg_sel_t    rd_sel;
    wire                 wr_fire  = aw_held_q & w_held_q & ~bvalid_q;
    wire                 wr_en    = wr_fire & wstrb0_q;
    wire                 ar_fire  = s_axi_arvalid_i & ~rvalid_q;
    wire                 busy     = (st_q == nv_pkg::WR_BUSY);
    wire                 ctrl_wr;
    wire                 launch;
    wire                 bad_go;
    wire                 rd_start;
    wire                 expire;
    wire                 to_array;
    wire                 flags_clr;
    wire [7:0]           ctrl_rd;
    wire [7:0]           flags_rd;
    wire [7:0]           rd_byte;

    assign wr_sel    = reg_sel(awaddr_q);
    assign rd_sel    = reg_sel(s_axi_araddr_i);
    assign ctrl_wr   = wr_en & (wr_sel == nv_pkg::SEL_CONTROL) & ~busy;
    // Permit taken from before this write, so one write setting both fails
    assign launch    = ctrl_wr & wdata_q[nv_pkg::CTL_WGO] & ~wgo_q
                     & (unl_q == nv_pkg::UNL_ARMED)
                     & permit_q
                     & pwrt_done_q;
    assign bad_go    = ctrl_wr & wdata_q[nv_pkg::CTL_WGO] & ~launch;
    assign rd_start  = ctrl_wr & wdata_q[nv_pkg::CTL_RGO]
                     & ~wdata_q[nv_pkg::CTL_SPACE]
                     & ~wdata_q[nv_pkg::CTL_CONFIG] & ~launch;
    assign expire    = busy & (cnt_q == 32'h0) & ~warm_rst_i;
    assign to_array  = ~space_q & ~config_q & ~erase_q;
    assign flags_clr = wr_en & (wr_sel == nv_pkg::SEL_FLAGS) & wdata_q[nv_pkg::FLG_DONE];
    assign ctrl_rd   = {space_q, config_q, 1'b0, erase_q, abort_q, permit_q, wgo_q, rgo_q};
    assign flags_rd  = {5'h00, busy, pwrt_done_q, done_q};
    assign rd_byte   = (rd_sel == nv_pkg::SEL_CONTROL) ? ctrl_rd :
                       (rd_sel == nv_pkg::SEL_DATA)    ? data_q  :
                       (rd_sel == nv_pkg::SEL_ADDRESS) ? addr_q  :
                       (rd_sel == nv_pkg::SEL_FLAGS)   ? flags_rd :
                       nv_pkg::RST_BYTE;

    assign s_axi_awready_o = ~aw_held_q;
    assign s_axi_wready_o  = ~w_held_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    assign write_busy_o    = busy;

    // Write address and data are taken in either order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (s_axi_awvalid_i && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_held_q <= 1'b0;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid_i && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i[7:0];
            wstrb0_q <= s_axi_wstrb_i[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= nv_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == nv_pkg::SEL_NONE) ? nv_pkg::RESP_SLVERR
                                                     : nv_pkg::RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= nv_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= (rd_sel == nv_pkg::SEL_NONE) ? nv_pkg::RESP_SLVERR
                                                     : nv_pkg::RESP_OKAY;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // Power-up timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwrt_cnt_q  <= 32'h0;
            pwrt_done_q <= 1'b0;
        end else if (!pwrt_done_q) begin
            pwrt_cnt_q  <= pwrt_cnt_q + 32'h1;
            pwrt_done_q <= (pwrt_cnt_q >= 32'(PWRT_CYCLES) - 32'h1);
        end
    end

    // Unlock sequence tracker; the port itself stores nothing
    always_ff @(posedge clk_i) begin
        if (rst_i || warm_rst_i) begin
            unl_q <= nv_pkg::UNL_IDLE;
        end else if (wr_en) begin
            if (wr_sel != nv_pkg::SEL_UNLOCK) begin
                unl_q <= nv_pkg::UNL_IDLE;
            end else if (wdata_q == nv_pkg::KEY_FIRST) begin
                unl_q <= nv_pkg::UNL_KEY1;
            end else if (wdata_q == nv_pkg::KEY_SECOND && unl_q == nv_pkg::UNL_KEY1) begin
                unl_q <= nv_pkg::UNL_ARMED;
            end else begin
                unl_q <= nv_pkg::UNL_IDLE;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            space_q  <= 1'b0;
            config_q <= 1'b0;
            erase_q  <= 1'b0;
            abort_q  <= 1'b0;
            permit_q <= 1'b0;
            wgo_q    <= 1'b0;
            rgo_q    <= 1'b0;
        end else if (warm_rst_i) begin
            // Abort flag and selects survive for tracing
            erase_q  <= 1'b0;
            wgo_q    <= 1'b0;
            rgo_q    <= 1'b0;
        end else begin
            rgo_q <= rd_start;
            if (ctrl_wr) begin
                space_q  <= wdata_q[nv_pkg::CTL_SPACE];
                config_q <= wdata_q[nv_pkg::CTL_CONFIG];
                erase_q  <= wdata_q[nv_pkg::CTL_ERASE];
                permit_q <= wdata_q[nv_pkg::CTL_PERMIT];
                abort_q  <= wdata_q[nv_pkg::CTL_ABORT] | launch | bad_go;
                wgo_q    <= launch;
            end
            if (expire) begin
                wgo_q   <= 1'b0;
                abort_q <= 1'b0;
                erase_q <= 1'b0;
            end
        end
    end

    // Self-timed write sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || warm_rst_i) begin
            st_q  <= nv_pkg::WR_IDLE;
            cnt_q <= 32'h0;
        end else begin
            case (st_q)
                nv_pkg::WR_IDLE: begin
                    if (launch) begin
                        st_q  <= nv_pkg::WR_BUSY;
                        cnt_q <= 32'(WRITE_CYCLES) - 32'h1;
                    end
                end
                nv_pkg::WR_BUSY: begin
                    if (cnt_q == 32'h0) begin
                        st_q <= nv_pkg::WR_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                default: begin
                    st_q <= nv_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // Array: erase-then-program modelled as one overwrite at expiry
    always_ff @(posedge clk_i) begin
        if (expire && to_array) begin
            mem_q[addr_q] <= data_q;
        end
    end

    // Address and data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= nv_pkg::RST_BYTE;
            data_q <= nv_pkg::RST_BYTE;
        end else begin
            if (rgo_q) begin
                data_q <= mem_q[addr_q];
            end
            if (wr_en && !busy && wr_sel == nv_pkg::SEL_DATA) begin
                data_q <= wdata_q;
            end
            if (wr_en && !busy && wr_sel == nv_pkg::SEL_ADDRESS) begin
                addr_q <= wdata_q;
            end
        end
    end

    // Done flag: write one clears, completion wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= expire | (done_q & ~flags_clr);
        end
    end

    // Independent record of the last two accepted register writes
    logic                key1_seen_q;
    logic                key2_seen_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key1_seen_q <= 1'b0;
            key2_seen_q <= 1'b0;
        end else if (wr_en) begin
            key1_seen_q <= (wr_sel == nv_pkg::SEL_UNLOCK) && (wdata_q == nv_pkg::KEY_FIRST);
            key2_seen_q <= (wr_sel == nv_pkg::SEL_UNLOCK) && (wdata_q == nv_pkg::KEY_SECOND)
                           && key1_seen_q;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_launch;
        launch;
    endsequence

    sequence s_started;
        busy && wgo_q && abort_q;
    endsequence

    sequence s_finished;
        !wgo_q && !abort_q && done_q && !busy;
    endsequence

    property p_launch_sets;
        s_launch |=> s_started;
    endproperty
    a_launch_sets: assert property (p_launch_sets)
        else $error("launch did not set go, abort and busy");

    property p_complete;
        expire |=> s_finished;
    endproperty
    a_complete: assert property (p_complete)
        else $error("expiry did not clear go and abort and set done");

    property p_no_double_set;
        ctrl_wr && !permit_q && !wgo_q |=> !wgo_q;
    endproperty
    a_no_double_set: assert property (p_no_double_set)
        else $error("write go set without earlier permit");

    property p_need_unlock;
        launch |-> key2_seen_q;
    endproperty
    a_need_unlock: assert property (p_need_unlock)
        else $error("write launched without unlock sequence");

    property p_read_next;
        rd_start |=> rgo_q ##1 (!rgo_q && data_q == mem_q[$past(addr_q)]);
    endproperty
    a_read_next: assert property (p_read_next)
        else $error("read byte not in data register next cycle");

    property p_read_refused;
        rgo_q |-> !space_q && !config_q;
    endproperty
    a_read_refused: assert property (p_read_refused)
        else $error("read started with program or config space selected");

    property p_frozen;
        busy && !warm_rst_i |=> $stable(addr_q) && $stable(data_q) && $stable(permit_q);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("registers changed during write");

    property p_unlock_zero;
        ar_fire && rd_sel == nv_pkg::SEL_UNLOCK |=> rdata_q == 32'h0000_0000;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read not zero");

    property p_pwrt_block;
        !pwrt_done_q |-> !launch;
    endproperty
    a_pwrt_block: assert property (p_pwrt_block)
        else $error("write launched during power-up timer");

    property p_warm_abort;
        busy && warm_rst_i |=> abort_q && !wgo_q && !busy && $stable(space_q);
    endproperty
    a_warm_abort: assert property (p_warm_abort)
        else $error("interrupted write lost abort flag or selects");

    property p_done_sticky;
        done_q && !flags_clr |=> done_q;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done flag cleared by hardware");

endmodule // nv_access_ctrl

// ### dv/nv_access_ctrl_tb.sv
// Self-checking bench for the nonvolatile access controller.
// Assumes the design's AXI4-Lite slave timing and short sim write/power-up counts.
`timescale 1ns/1ps
module nv_access_ctrl_tb;
    localparam int unsigned WCYC = 16;
    localparam int unsigned PCYC = 8;
    logic        clk_i;
    logic        rst_i;
    logic        warm_rst_i;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic [1:0]  last_bresp;
    logic        bvalid;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        busy;
    int          err_total;
    int          num_checks;
    int          cyc;

    nv_access_ctrl #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(PCYC)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .write_busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                last_bresp = bresp;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(name, {24'h000000, exp}, d);
        chk({name, " resp"}, {30'h0, nv_pkg::RESP_OKAY}, {30'h0, r});
    endtask

    task automatic launch(input logic [7:0] ctl);
        wr(nv_pkg::OFS_UNLOCK, nv_pkg::KEY_FIRST);
        wr(nv_pkg::OFS_UNLOCK, nv_pkg::KEY_SECOND);
        wr(nv_pkg::OFS_CONTROL, ctl);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rdc("flags early", nv_pkg::OFS_FLAGS, 8'h00);
        rdc("control reset", nv_pkg::OFS_CONTROL, 8'h00);
        wr(nv_pkg::OFS_UNLOCK, nv_pkg::KEY_FIRST);
        chk("unlock wr resp", {30'h0, nv_pkg::RESP_OKAY}, {30'h0, last_bresp});
        rdc("unlock", nv_pkg::OFS_UNLOCK, 8'h00);
        rd(8'h20, d, r);
        chk("unmapped resp", {30'h0, nv_pkg::RESP_SLVERR}, {30'h0, r});
        wr(8'h20, 8'h00);
        chk("unmapped wr resp", {30'h0, nv_pkg::RESP_SLVERR}, {30'h0, last_bresp});
    endtask

    task automatic t_write();
        int n;
        rdc("flags ready", nv_pkg::OFS_FLAGS, 8'h02);
        wr(nv_pkg::OFS_ADDRESS, 8'hff);
        wr(nv_pkg::OFS_DATA, 8'h5a);
        wr(nv_pkg::OFS_CONTROL, 8'h04);
        launch(8'h06);
        rdc("control busy", nv_pkg::OFS_CONTROL, 8'h0e);
        wr(nv_pkg::OFS_DATA, 8'h11);
        rdc("flags busy", nv_pkg::OFS_FLAGS, 8'h06);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk("busy end", 32'h0, {31'h0, busy});
        rdc("data held", nv_pkg::OFS_DATA, 8'h5a);
        rdc("control done", nv_pkg::OFS_CONTROL, 8'h04);
        rdc("flags done", nv_pkg::OFS_FLAGS, 8'h03);
        wr(nv_pkg::OFS_FLAGS, 8'h01);
        rdc("flags clear", nv_pkg::OFS_FLAGS, 8'h02);
        wr(nv_pkg::OFS_DATA, 8'h00);
        wr(nv_pkg::OFS_CONTROL, 8'h05);
        rdc("read go", nv_pkg::OFS_CONTROL, 8'h04);
        rdc("read data", nv_pkg::OFS_DATA, 8'h5a);
    endtask

    task automatic t_bad();
        wr(nv_pkg::OFS_UNLOCK, nv_pkg::KEY_SECOND);
        wr(nv_pkg::OFS_UNLOCK, nv_pkg::KEY_FIRST);
        wr(nv_pkg::OFS_CONTROL, 8'h06);
        rdc("bad order", nv_pkg::OFS_CONTROL, 8'h0c);
        chk("busy bad", 32'h0, {31'h0, busy});
        wr(nv_pkg::OFS_CONTROL, 8'h00);
        launch(8'h06);
        rdc("permit same", nv_pkg::OFS_CONTROL, 8'h0c);
        chk("busy same", 32'h0, {31'h0, busy});
    endtask

    task automatic t_sel();
        wr(nv_pkg::OFS_CONTROL, 8'h81);
        rdc("space read", nv_pkg::OFS_CONTROL, 8'h80);
        wr(nv_pkg::OFS_CONTROL, 8'h41);
        rdc("config read", nv_pkg::OFS_CONTROL, 8'h40);
        rdc("data kept", nv_pkg::OFS_DATA, 8'h5a);
    endtask

    task automatic t_warm();
        wr(nv_pkg::OFS_CONTROL, 8'h84);
        launch(8'h86);
        rdc("prog busy", nv_pkg::OFS_CONTROL, 8'h8e);
        warm_rst_i <= 1'b1;
        @(posedge clk_i);
        warm_rst_i <= 1'b0;
        @(posedge clk_i);
        chk("busy warm", 32'h0, {31'h0, busy});
        rdc("abort kept", nv_pkg::OFS_CONTROL, 8'h8c);
    endtask

    task automatic t_erase();
        int n;
        wr(nv_pkg::OFS_CONTROL, 8'h94);
        launch(8'h96);
        rdc("erase busy", nv_pkg::OFS_CONTROL, 8'h9e);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        rdc("erase done", nv_pkg::OFS_CONTROL, 8'h84);
        rdc("erase flag", nv_pkg::OFS_FLAGS, 8'h03);
    endtask

    initial begin
        rst_i = 1'b1;
        warm_rst_i = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wvalid = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_write();
        t_bad();
        t_sel();
        t_warm();
        t_erase();
        results();
    end
endmodule // nv_access_ctrl_tb
